/* include/link_cfg_pkg.sv */
package link_cfg_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register indices, byte address is four times the index
    localparam logic [9:0] LINK_CTRL_IDX  = 10'h200; // link and calibration enables, mode
    localparam logic [9:0] LINK_GEOM_IDX  = 10'h201; // base lane and converter counts
    localparam logic [9:0] LINK_STAT_IDX  = 10'h202; // derived link shape, read only
    localparam logic [9:0] CH_PAIR_EN_IDX = 10'h209; // channel_pair_enable
    localparam logic [9:0] SH_SEL_IDX     = 10'h20F; // sync_header_content_select

    ////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int unsigned FIRST_PAIR_BIT  = 0;
    localparam int unsigned SECOND_PAIR_BIT = 1;
    localparam int unsigned SINGLE_CH_BIT   = 2;
    localparam int unsigned LINK_EN_BIT     = 0;
    localparam int unsigned CAL_EN_BIT      = 1;
    localparam int unsigned MODE_LSB        = 8;
    localparam int unsigned MODE_W          = 5;
    localparam int unsigned GEOM_CONV_LSB   = 4;
    localparam int unsigned CNT_W           = 4;

    ////////////////////////////////////////////////////////////////////////////
    // reset values and encodings
    localparam logic [2:0]        CH_PAIR_EN_RST = 3'h3;
    localparam logic [1:0]        SH_SEL_RST     = 2'h0;
    localparam logic [1:0]        SH_CRC12       = 2'h0;
    localparam logic [1:0]        SH_FEC         = 2'h2;
    localparam logic [MODE_W-1:0] MODE_RST       = 5'h00;
    localparam logic [CNT_W-1:0]  BASE_LANE_RST  = 4'h8;
    localparam logic [CNT_W-1:0]  BASE_CONV_RST  = 4'h4;
    localparam logic [1:0]        RESP_OKAY      = 2'h0;
    localparam logic [1:0]        RESP_SLVERR    = 2'h2;
    localparam int unsigned       CRC_W          = 12;
    localparam int unsigned       FEC_W          = 26;
    localparam int unsigned       SH_WORD_W      = 32;

    ////////////////////////////////////////////////////////////////////////////
    // bus channel states
    typedef enum logic [0:0] {
        WR_IDLE = 1'b0,
        WR_RESP = 1'b1
    } wr_state_t;

    typedef enum logic [0:0] {
        RD_IDLE = 1'b0,
        RD_DATA = 1'b1
    } rd_state_t;

endpackage

/* logic/sync_header_builder.sv */
`timescale 1ns/1ps

module sync_header_builder
    import link_cfg_pkg::*;
(
    input  wire logic                          aclk,          // system clock
    input  wire logic                          aresetn,       // sync reset, active low
    input  wire logic                          active,        // 64b/66b mode selected
    input  wire logic [1:0]                    content_sel,   // header content select
    input  wire logic                          mb_start,      // multi-block boundary pulse
    input  wire logic [link_cfg_pkg::CRC_W-1:0] crc12_value,  // crc of last multi-block
    input  wire logic [link_cfg_pkg::FEC_W-1:0] fec_value,    // fec parity of last block
    output logic [link_cfg_pkg::SH_WORD_W-1:0] word,          // header word for next block
    output logic                               word_valid     // word holds a live stream
);

    typedef struct packed {
        logic [SH_WORD_W-1:0] word;
        logic                 valid;
    } sh_state_t;

    sh_state_t state_ff;
    sh_state_t nxt_state;

    ////////////////////////////////////////////////////////////////////////////
    // header word: command fields stay zero, so every header is idle
    always_comb begin
        nxt_state = state_ff;
        if (!active) begin
            nxt_state.word  = '0;
            nxt_state.valid = 1'b0;
        end else if (mb_start) begin
            case (content_sel)
                SH_CRC12: begin
                    nxt_state.word  = {crc12_value, 20'h00000};
                    nxt_state.valid = 1'b1;
                end
                SH_FEC: begin
                    nxt_state.word  = {6'h00, fec_value};
                    nxt_state.valid = 1'b1;
                end
                default: begin
                    nxt_state.word  = '0;                              // reserved: idle only
                    nxt_state.valid = 1'b0;
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign word       = state_ff.word;
    assign word_valid = state_ff.valid;

endmodule

/* logic/channel_enable_sync_header_cfg.sv */
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps

module channel_enable_sync_header_cfg
    import link_cfg_pkg::*;
#(
    parameter int unsigned ADDR_W           = 12,    // axi address width
    parameter logic [4:0]  MODE_66B_MIN     = 5'h10  // lowest link mode using 64b/66b
)
(
    input  wire logic                            aclk,           // system clock
    input  wire logic                            aresetn,        // sync reset, active low
    input  wire logic [ADDR_W-1:0]               s_axi_awaddr,   // write address
    input  wire logic [2:0]                      s_axi_awprot,   // write protection, unused
    input  wire logic                            s_axi_awvalid,  // write address valid
    output logic                                 s_axi_awready,  // write address ready
    input  wire logic [31:0]                     s_axi_wdata,    // write data
    input  wire logic [3:0]                      s_axi_wstrb,    // write byte strobes
    input  wire logic                            s_axi_wvalid,   // write data valid
    output logic                                 s_axi_wready,   // write data ready
    output logic [1:0]                           s_axi_bresp,    // write response
    output logic                                 s_axi_bvalid,   // write response valid
    input  wire logic                            s_axi_bready,   // write response ready
    input  wire logic [ADDR_W-1:0]               s_axi_araddr,   // read address
    input  wire logic [2:0]                      s_axi_arprot,   // read protection, unused
    input  wire logic                            s_axi_arvalid,  // read address valid
    output logic                                 s_axi_arready,  // read address ready
    output logic [31:0]                          s_axi_rdata,    // read data
    output logic [1:0]                           s_axi_rresp,    // read response
    output logic                                 s_axi_rvalid,   // read data valid
    input  wire logic                            s_axi_rready,   // read data ready
    input  wire logic                            mb_start,       // multi-block boundary pulse
    input  wire logic [link_cfg_pkg::CRC_W-1:0]  crc12_value,    // crc-12 of last block
    input  wire logic [link_cfg_pkg::FEC_W-1:0]  fec_value,      // fec parity of last block
    output logic [3:0]                           chan_enabled,   // channel D..A powered
    output logic [link_cfg_pkg::CNT_W-1:0]       lane_count,     // lanes in use
    output logic [link_cfg_pkg::CNT_W-1:0]       converter_count, // converters in use
    output logic                                 tail_bits_en,   // pad highest lane
    output logic                                 cd_in_ab_slots, // C, D samples in A, B slots
    output logic                                 single_channel_mode, // single-channel run
    output logic                                 link_enable,    // link enable bit
    output logic                                 calibration_enable, // calibration enable bit
    output logic [link_cfg_pkg::MODE_W-1:0]      link_mode_select, // link mode number
    output logic [link_cfg_pkg::SH_WORD_W-1:0]   sync_header_word, // header word per block
    output logic                                 sync_header_valid // header stream live
);

    ////////////////////////////////////////////////////////////////////////////
    // parameter checks
    if (ADDR_W < 12) begin : g_addr_chk
        $error("ADDR_W too small for the register map");
    end

    ////////////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed {
        wr_state_t         wst;
        logic              aw_got;
        logic              w_got;
        logic [9:0]        waddr;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              awready;
        logic              wready;
        logic              bvalid;
        logic [1:0]        bresp;
        rd_state_t         rst;
        logic              arready;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
        logic [2:0]        channel_pair_enable;
        logic [1:0]        sh_sel;
        logic              link_en;
        logic              cal_en;
        logic [MODE_W-1:0] mode;
        logic [CNT_W-1:0]  base_lanes;
        logic [CNT_W-1:0]  base_convs;
        logic [3:0]        chan_on;
        logic [CNT_W-1:0]  eff_lanes;
        logic [CNT_W-1:0]  eff_convs;
        logic              tail;
        logic              remap;
        logic              single;
        logic              sh_on;
    } cfg_state_t;

    cfg_state_t state_ff;
    cfg_state_t nxt_state;

    logic       aw_fire;
    logic       w_fire;
    logic       ar_fire;
    logic [9:0] wr_idx;
    logic [9:0] rd_idx;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic        halved;
    logic        ab_on;
    logic        cd_on;

    ////////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic is_mapped(input logic [9:0] idx);
        is_mapped = (idx == LINK_CTRL_IDX) || (idx == LINK_GEOM_IDX) ||
                    (idx == LINK_STAT_IDX) || (idx == CH_PAIR_EN_IDX) ||
                    (idx == SH_SEL_IDX);
    endfunction

    function automatic logic mode_is_66b(input logic [MODE_W-1:0] mode);
        mode_is_66b = (mode >= MODE_66B_MIN);
    endfunction

    function automatic logic [31:0] read_reg(input logic [9:0] idx, input cfg_state_t s);
        read_reg = 32'h00000000;
        case (idx)
            LINK_CTRL_IDX: begin
                read_reg[LINK_EN_BIT]               = s.link_en;
                read_reg[CAL_EN_BIT]                = s.cal_en;
                read_reg[MODE_LSB +: MODE_W]        = s.mode;
            end
            LINK_GEOM_IDX: begin
                read_reg[0 +: CNT_W]                = s.base_lanes;
                read_reg[GEOM_CONV_LSB +: CNT_W]    = s.base_convs;
            end
            LINK_STAT_IDX: begin
                read_reg[0 +: CNT_W]                = s.eff_lanes;
                read_reg[GEOM_CONV_LSB +: CNT_W]    = s.eff_convs;
                read_reg[8]                         = s.tail;
                read_reg[9]                         = s.remap;
                read_reg[10]                        = s.single;
                read_reg[11]                        = s.sh_on;
                read_reg[15:12]                     = s.chan_on;
            end
            CH_PAIR_EN_IDX: read_reg[2:0]           = s.channel_pair_enable;
            SH_SEL_IDX:     read_reg[1:0]           = s.sh_sel;
            default:        read_reg                = 32'h00000000;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // handshakes and the address and data of the write being committed
    assign aw_fire = s_axi_awvalid && state_ff.awready;
    assign w_fire  = s_axi_wvalid && state_ff.wready;
    assign ar_fire = s_axi_arvalid && state_ff.arready;
    assign wr_idx  = state_ff.aw_got ? state_ff.waddr : s_axi_awaddr[11:2];
    assign wr_data = state_ff.w_got ? state_ff.wdata : s_axi_wdata;
    assign wr_strb = state_ff.w_got ? state_ff.wstrb : s_axi_wstrb;
    assign rd_idx  = s_axi_araddr[11:2];

    ////////////////////////////////////////////////////////////////////////////
    // next state: bus channels, register writes, derived link shape
    always_comb begin
        nxt_state = state_ff;
        // write channel
        case (state_ff.wst)
            WR_IDLE: begin
                if (aw_fire) begin
                    nxt_state.aw_got = 1'b1;
                    nxt_state.waddr  = s_axi_awaddr[11:2];
                end
                if (w_fire) begin
                    nxt_state.w_got = 1'b1;
                    nxt_state.wdata = s_axi_wdata;
                    nxt_state.wstrb = s_axi_wstrb;
                end
                if ((state_ff.aw_got || aw_fire) && (state_ff.w_got || w_fire)) begin
                    nxt_state.wst     = WR_RESP;
                    nxt_state.bvalid  = 1'b1;
                    nxt_state.awready = 1'b0;
                    nxt_state.wready  = 1'b0;
                    nxt_state.bresp   = is_mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
                    // reserved bits are not stored and read back as zero
                    case (wr_idx)
                        LINK_CTRL_IDX: begin
                            if (wr_strb[0]) begin
                                nxt_state.link_en = wr_data[LINK_EN_BIT];
                                nxt_state.cal_en  = wr_data[CAL_EN_BIT];
                            end
                            if (wr_strb[1]) begin
                                nxt_state.mode = wr_data[MODE_LSB +: MODE_W];
                            end
                        end
                        LINK_GEOM_IDX: begin
                            if (wr_strb[0]) begin
                                nxt_state.base_lanes = wr_data[0 +: CNT_W];
                                nxt_state.base_convs = wr_data[GEOM_CONV_LSB +: CNT_W];
                            end
                        end
                        CH_PAIR_EN_IDX: begin
                            if (wr_strb[0]) begin
                                nxt_state.channel_pair_enable = wr_data[2:0];
                            end
                        end
                        SH_SEL_IDX: begin
                            if (wr_strb[0]) begin
                                nxt_state.sh_sel = wr_data[1:0];
                            end
                        end
                        default: begin
                            nxt_state.bresp = nxt_state.bresp;         // status and unmapped
                        end
                    endcase
                end else begin
                    nxt_state.awready = !nxt_state.aw_got;
                    nxt_state.wready  = !nxt_state.w_got;
                end
            end
            WR_RESP: begin
                if (s_axi_bready) begin
                    nxt_state.wst     = WR_IDLE;
                    nxt_state.bvalid  = 1'b0;
                    nxt_state.aw_got  = 1'b0;
                    nxt_state.w_got   = 1'b0;
                    nxt_state.awready = 1'b1;
                    nxt_state.wready  = 1'b1;
                end
            end
            default: begin
                nxt_state.wst = WR_IDLE;
            end
        endcase
        // read channel
        case (state_ff.rst)
            RD_IDLE: begin
                if (ar_fire) begin
                    nxt_state.rst     = RD_DATA;
                    nxt_state.arready = 1'b0;
                    nxt_state.rvalid  = 1'b1;
                    nxt_state.rdata   = read_reg(rd_idx, state_ff);
                    nxt_state.rresp   = is_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
                end
            end
            RD_DATA: begin
                if (s_axi_rready) begin
                    nxt_state.rst     = RD_IDLE;
                    nxt_state.rvalid  = 1'b0;
                    nxt_state.arready = 1'b1;
                end
            end
            default: begin
                nxt_state.rst = RD_IDLE;
            end
        endcase
        // pair enables after single-channel override, from the new configuration
        ab_on  = nxt_state.channel_pair_enable[FIRST_PAIR_BIT];
        cd_on  = nxt_state.channel_pair_enable[SECOND_PAIR_BIT] && !nxt_state.channel_pair_enable[SINGLE_CH_BIT];
        halved = !ab_on || !cd_on;
        // derived link shape from the new configuration
        nxt_state.single    = nxt_state.channel_pair_enable[SINGLE_CH_BIT];
        nxt_state.chan_on   = {cd_on, cd_on, ab_on & ~nxt_state.single, ab_on};
        nxt_state.eff_lanes = halved ? CNT_W'(({1'b0, nxt_state.base_lanes} + 5'h01) >> 1)
                                     : nxt_state.base_lanes;
        nxt_state.eff_convs = halved ? (nxt_state.base_convs >> 1)
                                     : nxt_state.base_convs;
        nxt_state.tail      = halved && nxt_state.base_lanes[0];
        nxt_state.remap     = !ab_on;
        nxt_state.sh_on     = mode_is_66b(nxt_state.mode);
    end

    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff            <= '0;
            state_ff.wst        <= WR_IDLE;
            state_ff.rst        <= RD_IDLE;
            state_ff.awready    <= 1'b1;
            state_ff.wready     <= 1'b1;
            state_ff.arready    <= 1'b1;
            state_ff.channel_pair_enable      <= CH_PAIR_EN_RST;
            state_ff.sh_sel     <= SH_SEL_RST;
            state_ff.mode       <= MODE_RST;
            state_ff.base_lanes <= BASE_LANE_RST;
            state_ff.base_convs <= BASE_CONV_RST;
            state_ff.chan_on    <= 4'hF;
            state_ff.eff_lanes  <= BASE_LANE_RST;
            state_ff.eff_convs  <= BASE_CONV_RST;
        end else begin
            state_ff <= nxt_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sync header stream
    sync_header_builder u_sh (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .active      (state_ff.sh_on),
        .content_sel (state_ff.sh_sel),
        .mb_start    (mb_start),
        .crc12_value (crc12_value),
        .fec_value   (fec_value),
        .word        (sync_header_word),
        .word_valid  (sync_header_valid)
    );

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign s_axi_awready       = state_ff.awready;
    assign s_axi_wready        = state_ff.wready;
    assign s_axi_bvalid        = state_ff.bvalid;
    assign s_axi_bresp         = state_ff.bresp;
    assign s_axi_arready       = state_ff.arready;
    assign s_axi_rvalid        = state_ff.rvalid;
    assign s_axi_rdata         = state_ff.rdata;
    assign s_axi_rresp         = state_ff.rresp;
    assign chan_enabled        = state_ff.chan_on;
    assign lane_count          = state_ff.eff_lanes;
    assign converter_count     = state_ff.eff_convs;
    assign tail_bits_en        = state_ff.tail;
    assign cd_in_ab_slots      = state_ff.remap;
    assign single_channel_mode = state_ff.single;
    assign link_enable         = state_ff.link_en;
    assign calibration_enable  = state_ff.cal_en;
    assign link_mode_select    = state_ff.mode;

endmodule

/* bench/link_rx_model.sv */
`timescale 1ns/1ps

module link_rx_model (
    input  wire logic        aclk,                  // system clock
    input  wire logic        aresetn,               // sync reset, active low
    output logic             mb_start,              // block boundary pulse
    output logic [11:0]      crc12_value = 12'hA5C, // crc of last block
    output logic [25:0]      fec_value = 26'h1F0E2D3 // parity of last block
);
    logic [2:0] cnt_ff = 3'h0;
    ////////////////////////////////////////
    // boundary every eight cycles; values move each block so a stale word shows
    always @(posedge aclk) begin
        cnt_ff <= aresetn ? cnt_ff + 3'h1 : 3'h0;
        if (mb_start) begin
            crc12_value <= {crc12_value[10:0], ~crc12_value[11]};
            fec_value   <= fec_value + 26'h123457;
        end
    end
    assign mb_start = (cnt_ff == 3'h7);
endmodule

/* bench/cfg_assertions.sv */
`timescale 1ns/1ps

module cfg_assertions #(
    parameter logic [4:0] MODE_66B_MIN = 5'h10 // lowest 64b/66b mode
) (
    input wire logic        aclk,                // clock
    input wire logic        aresetn,             // reset
    input wire logic        mb_start,            // block pulse
    input wire logic [3:0]  chan_enabled,        // channels
    input wire logic        tail_bits_en,        // padding
    input wire logic        cd_in_ab_slots,      // remap
    input wire logic        single_channel_mode, // single run
    input wire logic [4:0]  link_mode_select,    // mode
    input wire logic [31:0] sync_header_word,    // header word
    input wire logic        sync_header_valid    // header live
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////
    // channel gating and header stream relations
    single_off_a: assert property (single_channel_mode |-> chan_enabled[3:1] == 3'h0)
        else $error("single mode left a channel on");
    pair_gate_a: assert property (!single_channel_mode |->
        chan_enabled[3] == chan_enabled[2] && chan_enabled[1] == chan_enabled[0])
        else $error("pair halves differ");
    slot_remap_a: assert property (cd_in_ab_slots == !chan_enabled[0])
        else $error("slot remap wrong");
    tail_pad_a: assert property (tail_bits_en |-> chan_enabled != 4'hF)
        else $error("tail bits with full link");
    hdr_mode_a: assert property (sync_header_valid |->
        $past(link_mode_select) >= MODE_66B_MIN)
        else $error("header live outside 64b/66b");
    hdr_start_a: assert property ($rose(sync_header_valid) |-> $past(mb_start))
        else $error("header live without boundary");
    hdr_hold_a: assert property (sync_header_valid && $past(sync_header_valid) &&
        !$past(mb_start) |-> $stable(sync_header_word))
        else $error("header word moved mid block");
    idle_cmd_a: assert property (sync_header_valid |->
        sync_header_word[19:0] == 20'h0 || sync_header_word[31:26] == 6'h0)
        else $error("command field not idle");
    single_c: cover property (single_channel_mode);
    remap_c: cover property (cd_in_ab_slots);
    header_c: cover property (sync_header_valid);
endmodule

bind channel_enable_sync_header_cfg cfg_assertions #(.MODE_66B_MIN(MODE_66B_MIN)) u_chk (.*);

/* bench/channel_enable_sync_header_cfg_tb.sv */
`timescale 1ns/1ps

module channel_enable_sync_header_cfg_tb;
    import link_cfg_pkg::*;
    logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
    logic        rready = 0, awready, wready, bvalid, arready, rvalid, mb_start;
    logic        tail, remap, single, hvalid, len, cen;
    logic [4:0]  mode;
    logic [11:0] awaddr = 0, araddr = 0, crc;
    logic [31:0] wdata = 0, rdata, word;
    logic [25:0] fec;
    logic [1:0]  bresp, rresp;
    logic [3:0]  chan, lanes, convs;
    int          bad_count = 0, checks_done = 0;
    always #2 aclk = ~aclk;
    channel_enable_sync_header_cfg u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .mb_start(mb_start), .crc12_value(crc),
        .fec_value(fec), .chan_enabled(chan), .lane_count(lanes), .converter_count(convs),
        .tail_bits_en(tail), .cd_in_ab_slots(remap), .single_channel_mode(single),
        .link_enable(len), .calibration_enable(cen), .link_mode_select(mode),
        .sync_header_word(word), .sync_header_valid(hvalid));
    link_rx_model u_rx (.aclk(aclk), .aresetn(aresetn), .mb_start(mb_start), .crc12_value(crc),
        .fec_value(fec));
    ////////////////////////////////////////
    // compare, bus cycles sampled at the falling edge, released after the taking edge
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
        logic ta, tw, tb;
        @(posedge aclk);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
        do begin
            @(negedge aclk);
            {ta, tw, tb} = {awvalid & awready, wvalid & wready, bvalid};
            if (tb) chk(32'(bresp), 32'(er));
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) bready <= 1'b0;
        end while (!tb);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
        logic ta, tr;
        @(posedge aclk);
        {araddr, arvalid, rready} <= {a, 2'b11};
        do begin
            @(negedge aclk);
            {ta, tr} = {arvalid & arready, rvalid};
            if (tr) chk({rdata[29:0], rresp}, {e[29:0], er});
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
            if (tr) rready <= 1'b0;
        end while (!tr);
    endtask
    task automatic st(input logic [14:0] e);
        @(negedge aclk);
        chk(32'({chan, tail, remap, single, convs, lanes}), 32'(e));
    endtask
    task automatic hdr(input logic [1:0] s, input logic [4:0] m);
        logic [11:0] c;
        logic [25:0] f;
        logic        ok;
        ok = (m >= 5'h10) && !s[0];
        wr(12'h800, 32'h0);
        wr(12'h83C, {30'h0, s});
        wr(12'h800, {19'h0, m, 8'h00});
        do @(negedge aclk); while (mb_start !== 1'b1);
        {c, f} = {crc, fec};
        @(negedge aclk);
        chk(32'(hvalid), 32'(ok));
        chk(word, !ok ? 32'h0 : s[1] ? {6'h0, f} : {c, 20'h0});
    endtask
    task automatic final_report();
        if (bad_count == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    ////////////////////////////////////////
    // reset, channel pairing, error responses, header content per select and mode
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        st({4'hF, 3'b000, 4'h4, 4'h8});
        rd(12'h824, 32'h3);
        rd(12'h83C, 32'h0);
        wr(12'h800, 32'h0);
        wr(12'h804, 32'h47);
        wr(12'h824, 32'h1);
        st({4'h3, 3'b100, 4'h2, 4'h4});
        rd(12'h808, 32'h3124);
        wr(12'h824, 32'h2);
        st({4'hC, 3'b110, 4'h2, 4'h4});
        wr(12'h824, 32'h5);
        st({4'h1, 3'b101, 4'h2, 4'h4});
        wr(12'h824, 32'h3);
        st({4'hF, 3'b000, 4'h4, 4'h7});
        wr(12'h900, 32'h5, RESP_SLVERR);
        rd(12'h900, 32'h0, RESP_SLVERR);
        for (int i = 0; i < 4; i++) hdr(2'(i), 5'h10);
        hdr(2'h2, 5'h1F);
        hdr(2'h0, 5'h0F);
        wr(12'h800, 32'h1303);
        @(negedge aclk);
        chk(32'({len, cen, mode}), 32'h73);
        rd(12'h800, 32'h1303);
        rd(12'h808, 32'hF847);
        final_report();
    end
    // watchdog against a hung handshake
    initial begin
        #40000;
        bad_count++;
        final_report();
    end
endmodule
